// File: rtl/dcs_defines.vh
/*
 * Constants of the four-channel DMA sequencer: register offsets, field
 * positions, reset values and access timing counts.
 * Assumes inclusion by bare name from the sequencer design files.
 */
// Notes on behaviour
// RL1 - Request answered no sooner than four clocks
// RL2 - Read, one idle clock, then write
// RL3 - Internal RAM access lasts two clocks
// RL4 - Peripheral access three clocks plus waits
// RL5 - Soft trigger starts transfer when enabled
// RL6 - Software checks count before retriggering
// RL7 - Selected peripheral interrupt starts transfer
// RL8 - Never mix soft and hardware triggers
// RL9 - Requests during pending or active ignored
// RL10 - Bus hold suspends, release resumes
// RL11 - Terminal count clears enable, sets flag
// RL12 - No terminal count pin off chip
// RL13 - Active channel ignored, highest pending wins
// RL14 - Software programs wait control before use
// RL15 - Reading terminal count flag clears it
// RL16 - Software rereads flag three times
// RL17 - Init bit terminates, restores count
// RL18 - Pause-all termination is software's job
// RL19 - Software repeats init until count matches
// RL20 - Pending flag reads zero when idle
// RL21 - Enable low stops, high resumes
// RL22 - Halfword transfers force address bit zero
// RL23 - Fixed priority, zero highest, per cycle
// RL24 - Bus released after every single transfer
// RL25 - Count updated after each completed cycle
// RL26 - Enables, flags, pendings reset to zero
`ifndef DCS_DEFINES_VH
`define DCS_DEFINES_VH

// Per-channel register block and the global wait control offset
`define DCS_CH_STRIDE   8'h20
`define DCS_OFF_CTRL    5'h00
`define DCS_OFF_FACTOR  5'h04
`define DCS_OFF_COUNT   5'h08
`define DCS_OFF_SRC     5'h0C
`define DCS_OFF_DST     5'h10
`define DCS_OFF_WAITCTL 8'h80

// Control register fields
`define DCS_CTRL_EN     0
`define DCS_CTRL_STG    1
`define DCS_CTRL_INIT   2
`define DCS_CTRL_HALF   3
`define DCS_CTRL_TC     7

// Trigger factor register fields
`define DCS_FAC_HWSEL   6
`define DCS_FAC_PEND    7

// Reset values
`define DCS_WAIT_RST    8'h77
`define DCS_ZERO32      32'h0000_0000

// Address regions, taken from address bits 31:28
`define DCS_RAM_TAG     4'h3
`define DCS_PERI_TAG    4'hF

// Timing in clocks
`define DCS_RESP_CLKS   8'h04
`define DCS_RAM_CLKS    8'h02
`define DCS_PERI_CLKS   8'h03
`define DCS_EXT_CLKS    8'h02

`endif

// File: rtl/dcs_arbiter.v
/*
 * Pending request flags and fixed-priority selection for the channels.
 * Assumes request pulses are qualified by the caller and that grant is
 * consumed by the sequencer one cycle before take pulses.
 */
`default_nettype none

module dcs_arbiter #(
	parameter NCH = 4
) (
	input  wire           hclk,
	input  wire           hresetn,
	input  wire           ce,
	input  wire [NCH-1:0] req_in,
	input  wire [NCH-1:0] active,
	input  wire [NCH-1:0] allow,
	input  wire [NCH-1:0] take,
	input  wire [NCH-1:0] flush,
	output wire [NCH-1:0] pend,
	output wire [NCH-1:0] grant
);

	reg  [NCH-1:0] pend_r;   // Held requests
	wire [NCH-1:0] avail;    // Pending and permitted
	wire [NCH:0]   above;    // Some higher channel available

	assign pend  = pend_r;
	assign avail = pend_r & allow;
	assign above[0] = 1'b0;

	genvar i;
	generate
		for (i = 0; i < NCH; i = i + 1) begin : g_ch
			// Lower index always wins the grant
			assign grant[i]   = avail[i] & ~above[i];          // [RL23]
			assign above[i+1] = above[i] | avail[i];

			// Pending flag per channel
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pend_r[i] <= 1'b0;                          // [RL26]
				end else if (ce) begin
					if (flush[i] || take[i]) begin
						pend_r[i] <= 1'b0;                      // [RL20]
					end else if (req_in[i] && !active[i]) begin
						// Repeats while held or in flight are dropped
						pend_r[i] <= 1'b1;                      // [RL9] [RL13]
					end
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// File: rtl/dcs_top.v
/*
 * Four-channel single-transfer DMA sequencer with an AHB-Lite register
 * slave and a simple memory access port.
 * Assumes one AHB-Lite master, peripheral interrupt pulses synchronous
 * to hclk, and external pins already filtered for noise.
 */
// Chosen here: the AHB-Lite slave port and the address map.
`default_nettype none
`include "dcs_defines.vh"

module dcs_top #(
	parameter NCH  = 4,
	parameter NIRQ = 64,
	parameter CW   = 16
) (
	input  wire            hclk,
	input  wire            hresetn,
	input  wire            ce,
	input  wire            hsel,
	input  wire [31:0]     haddr,
	input  wire [1:0]      htrans,
	input  wire            hwrite,
	input  wire [2:0]      hsize,
	input  wire [31:0]     hwdata,
	input  wire            hready,
	output wire            hreadyout,
	output wire            hresp,
	output wire [31:0]     hrdata,
	input  wire [NIRQ-1:0] periph_irq,
	input  wire            bus_hold,
	output wire            mem_req,
	output wire            mem_we,
	output wire            mem_half,
	output wire [31:0]     mem_addr,
	output wire [15:0]     mem_wdata,
	input  wire [15:0]     mem_rdata,
	input  wire            ext_ready,
	output wire [NCH-1:0]  transfer_end_irq,
	output wire            dma_busy
);

	////////////////////////////////////////////////////////////////////
	// Sequencer states
	localparam [2:0] ST_IDLE  = 3'd0;
	localparam [2:0] ST_RESP  = 3'd1;
	localparam [2:0] ST_READ  = 3'd2;
	localparam [2:0] ST_GAP   = 3'd3;
	localparam [2:0] ST_WRITE = 3'd4;
	localparam [7:0] RESP_LD  = `DCS_RESP_CLKS - 8'h03;

	////////////////////////////////////////////////////////////////////
	// Channel state
	reg  [NCH-1:0]  en_r;             // Channel enables
	reg  [NCH-1:0]  tc_r;             // Terminal count flags
	reg  [NCH-1:0]  half_r;           // Halfword transfer size
	reg  [NCH-1:0]  hwsel_r;          // Hardware trigger selected
	reg  [5:0]      factor_r [0:NCH-1];
	reg  [CW-1:0]   count_r  [0:NCH-1];
	reg  [CW-1:0]   initc_r  [0:NCH-1];
	reg  [31:0]     src_r    [0:NCH-1];
	reg  [31:0]     dst_r    [0:NCH-1];
	reg  [7:0]      wait_r;           // Peripheral wait control
	reg  [NCH-1:0]  irq_r;            // End-of-transfer pulses

	// Bus slave state
	reg             ap_wr_r;          // Write data phase pending
	reg  [7:0]      ap_addr_r;        // Latched write address
	reg  [31:0]     hrdata_r;         // Read data

	// Sequencer state
	reg  [2:0]      state_r;
	reg  [1:0]      ch_r;             // Channel in service
	reg  [NCH-1:0]  act_r;            // One-hot active channel
	reg  [7:0]      acc_r;            // Access clocks remaining
	reg             mreq_r;
	reg             mwe_r;
	reg             mhalf_r;
	reg  [31:0]     maddr_r;
	reg  [15:0]     mwd_r;
	reg  [15:0]     data_r;           // Data between read and write
	reg  [NCH-1:0]  take_r;           // Grant acceptance pulse

	////////////////////////////////////////////////////////////////////
	// Bus decode
	wire        ap_go   = hsel & htrans[1] & hready;
	wire [2:0]  ap_ch   = haddr[7:5];
	wire [4:0]  ap_off  = haddr[4:0];
	wire [2:0]  wr_ch   = ap_addr_r[7:5];
	wire [4:0]  wr_off  = ap_addr_r[4:0];
	wire        ap_rd   = ap_go & ~hwrite;

	////////////////////////////////////////////////////////////////////
	// Request sources and arbitration
	wire [NCH-1:0] soft_req;
	wire [NCH-1:0] hw_req;
	wire [NCH-1:0] init_req;
	wire [NCH-1:0] ready;
	wire [NCH-1:0] pend;
	wire [NCH-1:0] grant;

	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : g_req
			// A channel may start only when enabled and not finished
			assign ready[g]    = en_r[g] & ~tc_r[g];
			assign soft_req[g] = ap_wr_r & (wr_ch == g) &
				(wr_off == `DCS_OFF_CTRL) & hwdata[`DCS_CTRL_STG];
			assign hw_req[g]   = hwsel_r[g] & periph_irq[factor_r[g]];
			assign init_req[g] = ap_wr_r & (wr_ch == g) &
				(wr_off == `DCS_OFF_CTRL) & hwdata[`DCS_CTRL_INIT];
		end
	endgenerate

	// Either trigger raises the same request; both at once count once
	wire [NCH-1:0] req_in = (soft_req | hw_req) & ready;  // [RL5] [RL7] [RL8]

	dcs_arbiter #(
		.NCH (NCH)
	) u_arb (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.req_in  (req_in),
		.active  (act_r),
		.allow   (ready),                                 // [RL21]
		.take    (take_r),
		.flush   (init_req),
		.pend    (pend),
		.grant   (grant)
	);

	// Index of the granted channel
	reg [1:0] gidx;
	integer k;
	always @* begin
		gidx = 2'd0;
		for (k = NCH - 1; k >= 0; k = k - 1) begin
			if (grant[k]) begin
				gidx = k[1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Access length for an address, less one
	function [7:0] acc_len;
		input [31:0] a;
		input [7:0]  w;
		begin
			if (a[31:28] == `DCS_RAM_TAG) begin
				acc_len = `DCS_RAM_CLKS - 8'h01;                      // [RL3]
			end else if (a[31:28] == `DCS_PERI_TAG) begin
				acc_len = `DCS_PERI_CLKS - 8'h01 + {4'h0, w[3:0]};   // [RL4]
			end else begin
				acc_len = `DCS_EXT_CLKS - 8'h01;
			end
		end
	endfunction

	// Halfword addresses drop bit zero
	function [31:0] align;
		input [31:0] a;
		input        h;
		begin
			align = h ? {a[31:1], 1'b0} : a;                         // [RL22]
		end
	endfunction

	wire        is_ext = (maddr_r[31:28] != `DCS_RAM_TAG) &&
		(maddr_r[31:28] != `DCS_PERI_TAG);
	// External accesses end when the memory says so
	wire        acc_end = (acc_r == 8'h00) && (!is_ext || ext_ready);
	wire [31:0] step    = mhalf_r ? 32'h0000_0002 : 32'h0000_0001;
	wire [31:0] rd_src  = align(src_r[ch_r], half_r[ch_r]);
	wire [31:0] wr_dst  = align(dst_r[ch_r], half_r[ch_r]);

	////////////////////////////////////////////////////////////////////
	// Sequencer: response delay, read, idle clock, write, release
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= ST_IDLE;
			ch_r    <= 2'd0;
			act_r   <= {NCH{1'b0}};
			acc_r   <= 8'h00;
			mreq_r  <= 1'b0;
			mwe_r   <= 1'b0;
			mhalf_r <= 1'b0;
			maddr_r <= `DCS_ZERO32;
			mwd_r   <= 16'h0000;
			data_r  <= 16'h0000;
			take_r  <= {NCH{1'b0}};
		end else if (ce) begin
			take_r <= {NCH{1'b0}};
			case (state_r)
				// Bus is free here for at least one clock
				ST_IDLE: begin
					act_r <= {NCH{1'b0}};
					if (!bus_hold && |grant) begin                    // [RL24]
						ch_r    <= gidx;
						act_r   <= grant;                             // [RL13]
						take_r  <= grant;
						acc_r   <= RESP_LD;
						state_r <= ST_RESP;
					end
				end
				// Pad the response out to its minimum
				ST_RESP: begin
					if (!bus_hold) begin
						if (acc_r == 8'h00) begin
							mreq_r  <= 1'b1;                          // [RL1]
							mwe_r   <= 1'b0;
							mhalf_r <= half_r[ch_r];
							maddr_r <= rd_src;
							acc_r   <= acc_len(rd_src, wait_r);
							state_r <= ST_READ;
						end else begin
							acc_r <= acc_r - 8'h01;
						end
					end
				end
				// Source read; a hold drops and later reissues it
				ST_READ: begin
					if (bus_hold) begin
						mreq_r <= 1'b0;                               // [RL10]
						acc_r  <= acc_len(maddr_r, wait_r);
					end else if (!mreq_r) begin
						mreq_r <= 1'b1;                               // [RL10]
					end else if (acc_end) begin
						mreq_r  <= 1'b0;
						data_r  <= mem_rdata;
						state_r <= ST_GAP;                            // [RL2]
					end else if (acc_r != 8'h00) begin
						acc_r <= acc_r - 8'h01;
					end
				end
				// One idle clock before the write, longer while bus_hold is high
				ST_GAP: begin
					if (!bus_hold) begin
						mreq_r  <= 1'b1;                              // [RL2]
						mwe_r   <= 1'b1;
						maddr_r <= wr_dst;
						mwd_r   <= data_r;
						acc_r   <= acc_len(wr_dst, wait_r);
						state_r <= ST_WRITE;
					end
				end
				// Destination write, then release the bus
				ST_WRITE: begin
					if (bus_hold) begin
						mreq_r <= 1'b0;                               // [RL10]
						acc_r  <= acc_len(maddr_r, wait_r);
					end else if (!mreq_r) begin
						mreq_r <= 1'b1;
					end else if (acc_end) begin
						mreq_r  <= 1'b0;
						mwe_r   <= 1'b0;
						state_r <= ST_IDLE;                           // [RL24]
					end else if (acc_r != 8'h00) begin
						acc_r <= acc_r - 8'h01;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Completion of a cycle, seen on the final write edge
	wire cyc_done = (state_r == ST_WRITE) && !bus_hold && mreq_r && acc_end;

	////////////////////////////////////////////////////////////////////
	// Bus slave: latch writes, answer reads from the address phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_r   <= 1'b0;
			ap_addr_r <= 8'h00;
			hrdata_r  <= `DCS_ZERO32;
		end else if (ce) begin
			ap_wr_r <= ap_go & hwrite;
			if (ap_go) begin
				ap_addr_r <= haddr[7:0];
			end
			if (ap_rd) begin
				hrdata_r <= `DCS_ZERO32;
				if (haddr[7:0] == `DCS_OFF_WAITCTL) begin
					hrdata_r <= {24'h00_0000, wait_r};
				end else if (ap_ch >= NCH || haddr[31:8] != 24'h00_0000) begin
					hrdata_r <= `DCS_ZERO32;
				end else if (ap_off == `DCS_OFF_CTRL) begin
					hrdata_r[`DCS_CTRL_EN]   <= en_r[ap_ch[1:0]];
					hrdata_r[`DCS_CTRL_HALF] <= half_r[ap_ch[1:0]];
					hrdata_r[`DCS_CTRL_TC]   <= tc_r[ap_ch[1:0]];
				end else if (ap_off == `DCS_OFF_FACTOR) begin
					hrdata_r[5:0]             <= factor_r[ap_ch[1:0]];
					hrdata_r[`DCS_FAC_HWSEL] <= hwsel_r[ap_ch[1:0]];
					hrdata_r[`DCS_FAC_PEND]  <= pend[ap_ch[1:0]];  // [RL20]
				end else if (ap_off == `DCS_OFF_COUNT) begin
					hrdata_r[CW-1:0] <= count_r[ap_ch[1:0]];       // [RL25]
				end else if (ap_off == `DCS_OFF_SRC) begin
					hrdata_r <= src_r[ap_ch[1:0]];
				end else if (ap_off == `DCS_OFF_DST) begin
					hrdata_r <= dst_r[ap_ch[1:0]];
				end
			end
		end
	end

	// Global peripheral wait control
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_r <= `DCS_WAIT_RST;
		end else if (ce && ap_wr_r && ap_addr_r == `DCS_OFF_WAITCTL) begin
			wait_r <= hwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Per-channel registers and completion handling
	genvar c;
	generate
		for (c = 0; c < NCH; c = c + 1) begin : g_chan
			wire wr_hit  = ap_wr_r && (wr_ch == c) && (ap_addr_r[7] == 1'b0);
			wire rd_ctrl = ap_rd && (ap_ch == c) && (ap_off == `DCS_OFF_CTRL) &&
				(haddr[31:8] == 24'h00_0000);
			wire fin     = cyc_done && (ch_r == c);
			wire last    = fin && (count_r[c] == {{(CW-1){1'b0}}, 1'b1});

			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					en_r[c]     <= 1'b0;                          // [RL26]
					tc_r[c]     <= 1'b0;
					half_r[c]   <= 1'b0;
					hwsel_r[c]  <= 1'b0;
					factor_r[c] <= 6'h00;
					count_r[c]  <= {CW{1'b0}};
					initc_r[c]  <= {CW{1'b0}};
					src_r[c]    <= `DCS_ZERO32;
					dst_r[c]    <= `DCS_ZERO32;
					irq_r[c]    <= 1'b0;
				end else if (ce) begin
					irq_r[c] <= last;                             // [RL11] [RL12]
					// Software writes
					if (wr_hit && wr_off == `DCS_OFF_CTRL) begin
						en_r[c]   <= hwdata[`DCS_CTRL_EN];        // [RL21]
						half_r[c] <= hwdata[`DCS_CTRL_HALF];
					end
					if (wr_hit && wr_off == `DCS_OFF_FACTOR) begin
						factor_r[c] <= hwdata[5:0];
						hwsel_r[c]  <= hwdata[`DCS_FAC_HWSEL];
					end
					if (wr_hit && wr_off == `DCS_OFF_SRC) begin
						src_r[c] <= hwdata;
					end
					if (wr_hit && wr_off == `DCS_OFF_DST) begin
						dst_r[c] <= hwdata;
					end
					// Count write also sets the reload value
					if (wr_hit && wr_off == `DCS_OFF_COUNT) begin
						count_r[c] <= hwdata[CW-1:0];
						initc_r[c] <= hwdata[CW-1:0];
					end else if (last || init_req[c]) begin
						count_r[c] <= initc_r[c];                 // [RL17]
					end else if (fin) begin
						count_r[c] <= count_r[c] - {{(CW-1){1'b0}}, 1'b1}; // [RL25]
					end
					// Addresses advance after each completed cycle
					if (fin) begin
						src_r[c] <= src_r[c] + step;
						dst_r[c] <= dst_r[c] + step;
					end
					// Terminal count: stop channel, flag sticks
					if (last) begin
						en_r[c] <= 1'b0;                          // [RL11]
						tc_r[c] <= 1'b1;
					end else if (init_req[c]) begin
						en_r[c] <= 1'b0;                          // [RL17]
					end else if (rd_ctrl) begin
						tc_r[c] <= 1'b0;                          // [RL15]
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Outputs, all from flip-flops
	reg hready_r;
	reg busy_r;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hready_r <= 1'b0;
			busy_r   <= 1'b0;
		end else if (ce) begin
			hready_r <= 1'b1;
			busy_r   <= (state_r != ST_IDLE) || (|grant && !bus_hold);
		end
	end

	assign hreadyout        = hready_r;
	assign hresp            = 1'b0 & hready_r;
	assign hrdata           = hrdata_r;
	assign mem_req          = mreq_r;
	assign mem_we           = mwe_r;
	assign mem_half         = mhalf_r;
	assign mem_addr         = maddr_r;
	assign mem_wdata        = mwd_r;
	assign transfer_end_irq = irq_r;
	assign dma_busy         = busy_r;

endmodule

`default_nettype wire

// File: verif/dcs_asserts.sv
/* Checker of the sequencer's access port and completion pulses.
   Assumes it is bound to dcs_top and sees only that module's ports. */
`default_nettype none
module dcs_checker #(
	parameter NCH  = 4,
	parameter NIRQ = 64,
	parameter CW   = 16
) (
	input wire logic           hclk,
	input wire logic           hresetn,
	input wire logic           bus_hold,
	input wire logic           mem_req,
	input wire logic           mem_we,
	input wire logic           mem_half,
	input wire logic [31:0]    mem_addr,
	input wire logic [NCH-1:0] transfer_end_irq,
	input wire logic           dma_busy
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////
	// A read starts only after a pending cycle and a grant
	a_resp_delay: assert property ($rose(mem_req) && !mem_we |-> $past(dma_busy, 2))
		else $error("read started too soon after request");
	// Read end is followed by one idle clock, then the write
	a_idle_gap: assert property ($fell(mem_req) && !$past(mem_we) && !$past(bus_hold)
		|=> (mem_req && mem_we) || $past(bus_hold))
		else $error("idle clock between read and write wrong");
	// RAM access lasts two clocks unless held
	a_ram_len: assert property ($rose(mem_req) && mem_addr[31:28] == 4'h3
		|=> (mem_req || $past(bus_hold)) ##1 !mem_req)
		else $error("RAM access length wrong");
	// Peripheral access lasts at least three clocks
	a_peri_min: assert property ($rose(mem_req) && mem_addr[31:28] == 4'hF && !bus_hold
		|=> mem_req[*2])
		else $error("peripheral access too short");
	// Hold takes the bus away at once and gives it back soon after release
	a_hold_drop: assert property (bus_hold && mem_req |=> !mem_req)
		else $error("access continued under bus hold");
	a_hold_resume: assert property ($fell(bus_hold) && dma_busy |-> ##[1:12] mem_req)
		else $error("access not resumed after hold");
	// Halfword accesses are aligned
	a_half_align: assert property (mem_req && mem_half |-> mem_addr[0] == 1'b0)
		else $error("odd halfword address");
	// End pulse follows a write and lasts one clock
	a_end_pulse: assert property (|transfer_end_irq
		|-> $past(mem_req && mem_we) ##1 (transfer_end_irq == '0))
		else $error("end pulse misplaced");
	// Bus is released after every write that no hold cut short
	a_bus_release: assert property ($fell(mem_req) && $past(mem_we) && !$past(bus_hold)
		|=> !mem_req[*2])
		else $error("bus not released after transfer");
	cover property (|transfer_end_irq);
	cover property (bus_hold && mem_req);
	cover property ($rose(mem_req) && mem_addr[31:28] == 4'hF);
	cover property ($rose(mem_req) && mem_we);
endmodule
`default_nettype wire

// File: verif/dcs_mem_model.sv
/* Memory and peripheral model on the sequencer's access port.
   Assumes halfword transfers; cell index is address bits 8:1. */
`default_nettype none
module dcs_mem_model (
	input  wire logic        hclk,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [31:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	input  wire logic [2:0]  ext_wait,
	output var  logic [15:0] mem_rdata,
	output var  logic        ext_ready
);
	logic [15:0] m [0:255];
	logic [15:0] last = 16'h0000;
	int          cnt = 0;
	wire  logic [7:0] idx = mem_addr[8:1];
	// Store writes, remember last read, count access clocks
	always @(posedge hclk) begin
		cnt <= mem_req ? cnt + 1 : 0;
		if (mem_req && mem_we) m[idx] <= mem_wdata;
		if (mem_req && !mem_we) last <= m[idx];
	end
	// Outside a read the data lines show the inverse of the last value
	assign mem_rdata = (mem_req && !mem_we) ? m[idx] : ~last;
	// External memory answers after its own wait count
	assign ext_ready = mem_req && (cnt >= ext_wait);
endmodule
`default_nettype wire

// File: verif/dma_channel_sequencer_bench.sv
/* Self-checking bench of the four-channel sequencer.
   Assumes the memory model on the access port and one AHB-Lite master. */
`default_nettype none
module dma_channel_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [63:0] ONE = 64'h0000_0000_0000_0001;
	logic        hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0;
	logic        hwrite = 1'b0, bus_hold = 1'b0;
	logic [1:0]  htrans = 2'b00;
	logic [2:0]  hsize = 3'b010, ext_wait = 3'h3;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, q;
	logic [63:0] periph_irq = 64'h0000_0000_0000_0000;
	wire  logic  hreadyout, hresp, mem_req, mem_we, mem_half, ext_ready, dma_busy;
	wire  logic [31:0] hrdata, mem_addr;
	wire  logic [15:0] mem_wdata, mem_rdata;
	wire  logic [3:0]  transfer_end_irq;
	int          n_errors = 0, num_checks = 0, nend = 0, len = 0, t;
	int          lens[$], cnt[4], rel[4];
	logic [31:0] seed = 32'hdb6b_3027, rq[$], erq[$];
	logic        pv = 1'b0;
	bit          tc[4], en[4];
	logic [5:0]  k;
	dcs_top #(.NCH(4), .NIRQ(64), .CW(16)) dut (
		.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.periph_irq(periph_irq), .bus_hold(bus_hold), .mem_req(mem_req), .mem_we(mem_we),
		.mem_half(mem_half), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .ext_ready(ext_ready),
		.transfer_end_irq(transfer_end_irq), .dma_busy(dma_busy));
	dcs_mem_model mm (
		.hclk(hclk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .ext_wait(ext_wait), .mem_rdata(mem_rdata),
		.ext_ready(ext_ready));
	initial begin
		forever #20 hclk = ~hclk;
	end
	// Watch read starts, access lengths and end pulses
	always @(posedge hclk) begin
		pv <= mem_req;
		nend <= nend + $countones(transfer_end_irq);
		if (mem_req && !pv && !mem_we) rq.push_back(mem_addr);
		if (mem_req) len <= len + 1;
		else if (pv) begin
			lens.push_back(len);
			len <= 0;
		end
	end
	////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Wait for an edge with hready high, bounded
	task automatic step();
		t = 0;
		do begin
			@(posedge hclk);
			t++;
		end while (hreadyout !== 1'b1 && t < 20);
		if (t >= 20) n_errors++;
	endtask
	task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		step();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		step();
		r = hrdata;
		chk({31'h0000_0000, hresp}, 32'h0000_0000);
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] r);
		ahb(1'b0, a, 32'h0000_0000, r);
	endtask
	task automatic pulse(input logic [63:0] v);
		@(posedge hclk);
		periph_irq <= v;
		@(posedge hclk);
		periph_irq <= 64'h0000_0000_0000_0000;
	endtask
	task automatic wait_req();
		t = 0;
		while (mem_req !== 1'b1 && t < 50) begin
			@(posedge hclk);
			t++;
		end
		if (mem_req !== 1'b1) n_errors++;
	endtask
	// Wait until the sequencer has been quiet for eight clocks
	task automatic idle();
		int n;
		n = 0;
		t = 0;
		while (n < 8 && t < 3000) begin
			@(posedge hclk);
			n = (dma_busy === 1'b0 && mem_req === 1'b0) ? n + 1 : 0;
			t++;
		end
		if (t >= 3000) n_errors++;
	endtask
	// Model: one completed transfer on channel c
	task automatic done(input int c);
		cnt[c]--;
		if (cnt[c] == 0) begin
			cnt[c] = rel[c];
			tc[c] = 1'b1;
			en[c] = 1'b0;
		end
	endtask
	task automatic setup(input int c, input logic [31:0] s, d, n, f);
		wr(c * 32 + 12, s);
		wr(c * 32 + 16, d);
		wr(c * 32 + 8, n);
		wr(c * 32 + 4, f);
		wr(c * 32, 32'h0000_0009);
		cnt[c] = n;
		rel[c] = n;
		tc[c] = 1'b0;
		en[c] = 1'b1;
	endtask
	// Compare count and control of channel c with the model
	task automatic state(input int c);
		rd(c * 32 + 8, q);
		chk(q, cnt[c]);
		rd(c * 32, q);
		chk(q, {24'h00_0000, tc[c], 3'h0, 1'b1, 2'h0, en[c]});
		tc[c] = 1'b0;
	endtask
	////////////////////////////////////////
	initial begin
		#2_000_000;
		n_errors++;
		summarize();
	end
	initial begin
		for (int i = 0; i < 256; i++) begin
			q = rnd();
			mm.m[i] = q[15:0];
		end
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		// Reset state and an unmapped address
		for (int c = 0; c < 4; c++) begin
			rd(c * 32, q);
			chk(q, 32'h0000_0000);
			rd(c * 32 + 4, q);
			chk(q, 32'h0000_0000);
		end
		rd(32'h0000_0080, q);
		chk(q, 32'h0000_0077);
		rd(32'h0000_0084, q);
		chk(q, 32'h0000_0000);
		wr(32'h0000_0080, 32'h0000_0002);
		// Soft trigger, repeated trigger, hold in mid-read, terminal count
		setup(0, 32'h3000_0011, 32'h3000_0040, 2, 0);
		wr(0, 32'h0000_000b);
		wr(0, 32'h0000_000b);
		wait_req();
		bus_hold <= 1'b1;
		repeat (4) @(posedge hclk);
		bus_hold <= 1'b0;
		idle();
		done(0);
		state(0);
		wr(0, 32'h0000_000b);
		idle();
		done(0);
		repeat (3) state(0);
		chk(mm.m[8'h20], mm.m[8'h08]);
		chk(mm.m[8'h21], mm.m[8'h09]);
		// Peripheral interrupt trigger, only the selected one counts
		q = rnd();
		k = q[5:0];
		setup(1, 32'hf000_0000, 32'h3000_0080, 1, {25'h000_0000, 1'b1, k});
		pulse(ONE << (k ^ 6'h01));
		idle();
		state(1);
		lens.delete();
		pulse(ONE << k);
		idle();
		done(1);
		state(1);
		chk(lens[0], 5);
		chk(lens[1], 2);
		// Priority, held lower channel, ignored repeat of the active one
		ext_wait <= 3'h4;
		setup(2, 32'h3000_00a0, 32'h3000_00c0, 2, 32'h0000_004a);
		setup(3, 32'h0000_0100, 32'h3000_0140, 1, 32'h0000_004b);
		rq.delete();
		pulse(ONE << 10 | ONE << 11);
		wait_req();
		pulse(ONE << 10);
		idle();
		pulse(ONE << 10);
		idle();
		erq = '{32'h3000_00a0, 32'h0000_0100, 32'h3000_00a2};
		chk(rq.size(), 3);
		foreach (erq[i]) chk(rq[i], erq[i]);
		done(2);
		done(3);
		done(2);
		state(2);
		state(3);
		// Stop by enable, resume without reload, then initialize
		setup(1, 32'hf000_0010, 32'h3000_00e0, 3, {25'h000_0000, 1'b1, k});
		pulse(ONE << k);
		idle();
		done(1);
		wr(32, 32'h0000_0008);
		en[1] = 1'b0;
		pulse(ONE << k);
		idle();
		state(1);
		rd(36, q);
		chk(q, {25'h000_0000, 1'b1, k});
		wr(32, 32'h0000_0009);
		en[1] = 1'b1;
		pulse(ONE << k);
		idle();
		done(1);
		state(1);
		wr(32, 32'h0000_0008);
		wr(32, 32'h0000_0008);
		wr(32, 32'h0000_000d);
		en[1] = 1'b0;
		cnt[1] = rel[1];
		state(1);
		chk(nend, 4);
		summarize();
	end
endmodule
bind dcs_top dcs_checker #(.NCH(NCH), .NIRQ(NIRQ), .CW(CW)) u_chk (
	.hclk(hclk), .hresetn(hresetn), .bus_hold(bus_hold), .mem_req(mem_req),
	.mem_we(mem_we), .mem_half(mem_half), .mem_addr(mem_addr),
	.transfer_end_irq(transfer_end_irq), .dma_busy(dma_busy));
`default_nettype wire
